// [sdl_link.sv]
// Synchronous data set link: transmit sequencer, idle fill and receiver
// Summary of operation
// - Forwarding lasts while send request held
// - Transmit bit changes on tx clock rise
// - Idle character sent whenever no data
// - Receive timing taken from data set clock
// - Receive line sampled on rx clock fall
// - Value one means mark, control off
// - Value zero means space, control on
// - Open or unpowered input reads as mark
`timescale 1ns/1ps
module sdl_link
	import sdl_pkg::*;
(
	input wire logic ref_clk, // System clock, 125 MHz
	input wire logic rst_b, // Asynchronous reset, active low
	input wire logic rx_bit_clock, // Receive bit clock from data set
	input wire logic tx_bit_clock, // Transmit bit clock from data set
	input wire logic clear_to_send, // Line level, 0 = on
	input wire logic carrier_detect, // Line level, 0 = on
	input wire logic interlock_ok, // Line level, 0 = on
	input wire logic rx_data_line, // Serial receive data
	output logic tx_data_line, // Serial transmit data
	output logic send_request, // Line level, 0 = on
	input wire logic tx_valid, // Byte offered for sending
	input wire logic [7:0] tx_data, // Byte to send
	output logic tx_ready, // Buffer can take a byte
	output logic rx_valid, // One-cycle pulse, byte received
	output logic [7:0] rx_data, // Received byte
	output logic link_ready, // Interlock seen on
	output logic carrier_on, // Carrier seen on
	output logic rx_synced // Receiver in character phase
);
	// Reset release, system domain
	logic rst_s1_q, rst_n;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_q <= RST_ACTIVE;
			rst_n <= RST_ACTIVE;
		end else begin
			rst_s1_q <= ~RST_ACTIVE;
			rst_n <= rst_s1_q;
		end
	end

	// Input synchronisers; reset to mark so an idle line reads off
	logic txc_s1_q, txc_s2_q, txc_s3_q;
	logic cts_s1_q, cts_s2_q, il_s1_q, il_s2_q, cd_s1_q, cd_s2_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			txc_s1_q <= LINE_MARK;
			txc_s2_q <= LINE_MARK;
			txc_s3_q <= LINE_MARK;
			cts_s1_q <= LINE_MARK;
			cts_s2_q <= LINE_MARK;
			il_s1_q <= LINE_MARK;
			il_s2_q <= LINE_MARK;
			cd_s1_q <= LINE_MARK;
			cd_s2_q <= LINE_MARK;
		end else begin
			txc_s1_q <= tx_bit_clock;
			txc_s2_q <= txc_s1_q;
			txc_s3_q <= txc_s2_q;
			cts_s1_q <= clear_to_send;
			cts_s2_q <= cts_s1_q;
			il_s1_q <= interlock_ok;
			il_s2_q <= il_s1_q;
			cd_s1_q <= carrier_detect;
			cd_s2_q <= cd_s1_q;
		end
	end

	// Control on is a space on the line
	logic tx_rise, cts_on, il_on;
	assign tx_rise = txc_s2_q && !txc_s3_q;
	assign cts_on = (cts_s2_q == LINE_SPACE);
	assign il_on = (il_s2_q == LINE_SPACE);
	assign link_ready = il_on;
	assign carrier_on = (cd_s2_q == LINE_SPACE);

	// Transmit buffer
	sdl_stream_if #(.W(BYTE_W)) fill_if ();
	sdl_stream_if #(.W(BYTE_W)) drain_if ();
	assign fill_if.valid = tx_valid;
	assign fill_if.data = tx_data;
	assign tx_ready = fill_if.ready;
	sdl_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_sdl_fifo (
		.clk(ref_clk),
		.rst_n(rst_n),
		.in_if(fill_if),
		.out_if(drain_if)
	);

	// Transmit sequencer state
	sdl_tx_state_t state_q, state_d;
	logic [7:0] tx_char_q, tx_char_d;
	logic [2:0] bit_cnt_q, bit_cnt_d;
	logic tx_line_q, tx_line_d;
	logic load_char, take_data;

	assign load_char = tx_rise && (bit_cnt_q == BIT_LAST);
	assign take_data = load_char && cts_on && il_on && drain_if.valid
		&& (state_q != ST_IDLE);
	assign drain_if.ready = take_data;

	// Next bit, next character and request state
	always_comb begin
		state_d = state_q;
		tx_char_d = tx_char_q;
		bit_cnt_d = bit_cnt_q;
		tx_line_d = tx_line_q;
		if (tx_rise) begin
			tx_line_d = tx_char_q[bit_cnt_q];
			bit_cnt_d = bit_cnt_q + BIT_STEP;
		end
		if (load_char) begin
			bit_cnt_d = BIT_FIRST;
			tx_char_d = take_data ? drain_if.data : IDLE_CHAR;
			case (state_q)
				ST_IDLE: begin
					if (drain_if.valid && il_on) begin
						state_d = ST_WAIT_CTS;
					end
				end
				ST_WAIT_CTS: begin
					if (take_data) begin
						state_d = ST_SEND;
					end
				end
				ST_SEND: begin
					if (take_data) begin
						state_d = ST_SEND;
					end else if (drain_if.valid) begin
						state_d = ST_WAIT_CTS;
					end else begin
						state_d = ST_DRAIN;
					end
				end
				ST_DRAIN: begin
					state_d = take_data ? ST_SEND : ST_IDLE;
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
		if (!il_on) begin
			state_d = ST_IDLE;
		end
	end

	// Transmit sequencer registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			tx_char_q <= IDLE_CHAR;
			bit_cnt_q <= BIT_FIRST;
			tx_line_q <= LINE_MARK;
		end else begin
			state_q <= state_d;
			tx_char_q <= tx_char_d;
			bit_cnt_q <= bit_cnt_d;
			tx_line_q <= tx_line_d;
		end
	end

	// Request is on (space) outside the idle state
	assign send_request = (state_q == ST_IDLE) ? LINE_MARK : LINE_SPACE;
	assign tx_data_line = tx_line_q;

	// Receive domain reset release on the data set clock
	logic rx_rst_s1_q, rx_rst_n;
	always_ff @(negedge rx_bit_clock or negedge rst_b) begin
		if (!rst_b) begin
			rx_rst_s1_q <= RST_ACTIVE;
			rx_rst_n <= RST_ACTIVE;
		end else begin
			rx_rst_s1_q <= ~RST_ACTIVE;
			rx_rst_n <= rx_rst_s1_q;
		end
	end

	// Receive line and carrier staged on the falling edge
	logic rxd_s1_q, rxd_s2_q, rcd_s1_q, rcd_s2_q;
	always_ff @(negedge rx_bit_clock or negedge rx_rst_n) begin
		if (!rx_rst_n) begin
			rxd_s1_q <= LINE_MARK;
			rxd_s2_q <= LINE_MARK;
			rcd_s1_q <= LINE_MARK;
			rcd_s2_q <= LINE_MARK;
		end else begin
			rxd_s1_q <= rx_data_line;
			rxd_s2_q <= rxd_s1_q;
			rcd_s1_q <= carrier_detect;
			rcd_s2_q <= rcd_s1_q;
		end
	end

	// Receive shifter, character hunt and word hand-off
	logic [7:0] rx_sh_q, rx_sh_d, rx_word_q, rx_word_d;
	logic [2:0] rx_cnt_q, rx_cnt_d;
	logic rx_sync_q, rx_sync_d, rx_tgl_q, rx_tgl_d;
	always_comb begin
		rx_sh_d = {rxd_s2_q, rx_sh_q[7:1]};
		rx_cnt_d = rx_cnt_q + BIT_STEP;
		rx_sync_d = rx_sync_q;
		rx_word_d = rx_word_q;
		rx_tgl_d = rx_tgl_q;
		if (rcd_s2_q != LINE_SPACE) begin
			rx_sync_d = 1'b0;
			rx_cnt_d = BIT_FIRST;
		end else if (!rx_sync_q) begin
			rx_cnt_d = BIT_FIRST;
			rx_sync_d = (rx_sh_d == IDLE_CHAR);
		end else if (rx_cnt_q == BIT_LAST) begin
			if (rx_sh_d != IDLE_CHAR) begin
				rx_word_d = rx_sh_d;
				rx_tgl_d = ~rx_tgl_q;
			end
		end
	end

	// Receive registers, clocked by the data set clock
	always_ff @(negedge rx_bit_clock or negedge rx_rst_n) begin
		if (!rx_rst_n) begin
			rx_sh_q <= '0;
			rx_cnt_q <= BIT_FIRST;
			rx_sync_q <= 1'b0;
			rx_word_q <= '0;
			rx_tgl_q <= 1'b0;
		end else begin
			rx_sh_q <= rx_sh_d;
			rx_cnt_q <= rx_cnt_d;
			rx_sync_q <= rx_sync_d;
			rx_word_q <= rx_word_d;
			rx_tgl_q <= rx_tgl_d;
		end
	end

	// Word toggle and sync level into the system domain
	logic tg_s1_q, tg_s2_q, tg_s3_q, sy_s1_q, sy_s2_q;
	logic [7:0] rx_data_q, rx_data_d;
	logic rx_valid_q, rx_valid_d;
	always_comb begin
		rx_valid_d = tg_s2_q ^ tg_s3_q;
		rx_data_d = rx_valid_d ? rx_word_q : rx_data_q;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tg_s1_q <= 1'b0;
			tg_s2_q <= 1'b0;
			tg_s3_q <= 1'b0;
			sy_s1_q <= 1'b0;
			sy_s2_q <= 1'b0;
			rx_data_q <= '0;
			rx_valid_q <= 1'b0;
		end else begin
			tg_s1_q <= rx_tgl_q;
			tg_s2_q <= tg_s1_q;
			tg_s3_q <= tg_s2_q;
			sy_s1_q <= rx_sync_q;
			sy_s2_q <= sy_s1_q;
			rx_data_q <= rx_data_d;
			rx_valid_q <= rx_valid_d;
		end
	end
	assign rx_valid = rx_valid_q;
	assign rx_data = rx_data_q;
	assign rx_synced = sy_s2_q;

	// Checks on the system domain, the shifter check on the receive clock
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_tx_bit_edge: assert property ($changed(tx_data_line) |-> $past(tx_rise))
		else $error("transmit line changed without a tx clock rise");
	a_idle_fill: assert property ((load_char && !take_data) |=> tx_char_q == IDLE_CHAR)
		else $error("idle character not loaded when no data taken");
	a_cts_gate: assert property (take_data |-> (cts_s2_q == LINE_SPACE) && state_q != ST_IDLE)
		else $error("data loaded without clear to send");
	a_req_mark: assert property ((state_q == ST_IDLE) |-> send_request == LINE_MARK)
		else $error("request on while idle");
	a_ilk_drop: assert property (!il_on |=> send_request == LINE_MARK)
		else $error("request left on with interlock off");
	a_req_hold: assert property ((state_q == ST_SEND && !load_char && il_on) |=>
		state_q == ST_SEND && send_request == LINE_SPACE)
		else $error("request dropped inside a character");
	a_sync_mark: assert property ($rose(rst_n) |-> cts_s2_q && il_s2_q && cd_s2_q)
		else $error("synchroniser not at mark after reset");
	a_sync_lag: assert property (cts_on |-> $past(clear_to_send, 2) == LINE_SPACE)
		else $error("clear to send used without two stages");
	a_rx_shift: assert property (@(negedge rx_bit_clock) disable iff (!rx_rst_n)
		rx_rst_n |=> rx_sh_q[7] == $past(rxd_s2_q))
		else $error("receive shifter missed a bit");
	a_rx_pulse: assert property (rx_valid |=> !rx_valid)
		else $error("receive strobe longer than one cycle");

	c_send_start: cover property ((state_q == ST_WAIT_CTS) ##[1:1000] (state_q == ST_SEND));
	c_drain_idle: cover property ((state_q == ST_DRAIN) ##[1:1000] (state_q == ST_IDLE));
	c_rx_byte: cover property (rx_valid);
	c_fifo_full: cover property (!tx_ready);
endmodule

// [sdl_pkg.sv]
// Shared constants and types for the synchronous data set link
package sdl_pkg;
	localparam int BYTE_W = 8;
	localparam int FIFO_DEPTH = 8;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_STEP = 3'h1;
	// Idle fill character; plain default encoding
	localparam logic [7:0] IDLE_CHAR = 8'h32;
	// Line sense: mark is control off, space is control on
	localparam logic LINE_MARK = 1'h1;
	localparam logic LINE_SPACE = 1'h0;
	// Reset value of the reset synchroniser stages
	localparam logic RST_ACTIVE = 1'h0;

	// Transmit request sequencer, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT_CTS = 4'h2,
		ST_SEND = 4'h4,
		ST_DRAIN = 4'h8
	} sdl_tx_state_t;
endpackage

// [sdl_stream_if.sv]
// Valid/ready byte stream between the link modules
`timescale 1ns/1ps
interface sdl_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// [sdl_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sdl_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Synchronised reset, active low
	sdl_stream_if.snk in_if, // Fill side
	sdl_stream_if.src out_if // Drain side
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] PTR_STEP = (AW + 1)'(1);
	localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(D);

	logic [W-1:0] mem_q [D];
	logic [AW:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] fill;
	logic push, pop;

	// Occupancy and handshakes
	assign fill = wr_q - rd_q;
	assign in_if.ready = (fill != DEPTH_CNT);
	assign out_if.valid = (fill != '0);
	assign out_if.data = mem_q[rd_q[AW-1:0]];
	assign push = in_if.valid && in_if.ready;
	assign pop = out_if.valid && out_if.ready;

	// Pointer next values
	always_comb begin
		wr_d = push ? wr_q + PTR_STEP : wr_q;
		rd_d = pop ? rd_q + PTR_STEP : rd_q;
	end

	// Pointer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	// Storage, written only on a push
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_if.data;
		end
	end
endmodule

// [sdl_dataset_model.sv]
// Data set model: bit clocks, clear answer, send line capture, receive feed
`timescale 1ns/1ps
module sdl_dataset_model
	import sdl_pkg::*;
(
	input wire logic send_request, // From link, 0 = on
	input wire logic tx_data_line, // From link
	input wire logic ilk_en, // Bench: interlock on
	input wire logic car_en, // Bench: carrier on
	input wire logic cts_block, // Bench: withhold clear
	output logic tx_bit_clock, // Transmit timing
	output logic rx_bit_clock, // Receive timing
	output logic clear_to_send, // 0 = on
	output logic carrier_detect, // 0 = on
	output logic interlock_ok, // 0 = on
	output logic rx_data_line // Serial receive data
);
	logic [7:0] sh = 8'hff;
	logic [7:0] cur = 8'hff;
	logic [7:0] got_q[$];
	logic [7:0] rx_q[$];
	int cnt = 0;
	int dly = 0;
	int idle_cnt = 0;
	int rbit = 0;
	bit lock = 0;
	// Free-running clocks, 32 ns, phase unrelated to ref_clk
	initial begin
		tx_bit_clock = 0;
		#5.3;
		forever #16 tx_bit_clock = ~tx_bit_clock;
	end
	initial begin
		rx_bit_clock = 1;
		#0.5;
		forever #16 rx_bit_clock = ~rx_bit_clock;
	end
	// On is space, off or unpowered is mark
	assign interlock_ok = ilk_en ? LINE_SPACE : LINE_MARK;
	assign carrier_detect = car_en ? LINE_SPACE : LINE_MARK;
	// Clear follows the request after a few bits, drops with it
	always @(posedge tx_bit_clock) begin
		dly = (send_request === LINE_SPACE) ? dly + 1 : 0;
		clear_to_send <= (dly > 2 && !cts_block) ? LINE_SPACE : LINE_MARK;
	end
	// Sample on falls; forward only while request and clear on
	always @(negedge tx_bit_clock) begin
		sh = {tx_data_line, sh[7:1]};
		cnt = lock ? cnt + 1 : 0;
		if (!lock && sh === IDLE_CHAR) begin
			lock = 1;
		end else if (lock && cnt == 8) begin
			cnt = 0;
			if (sh === IDLE_CHAR)
				idle_cnt++;
			else if (send_request === LINE_SPACE && clear_to_send === LINE_SPACE)
				got_q.push_back(sh);
		end
	end
	// Receive bits change on rises only; idle fill between bytes
	always @(posedge rx_bit_clock) begin
		if (!car_en) begin
			rbit = 0;
			rx_data_line <= LINE_MARK;
		end else begin
			if (rbit == 0 && rx_q.size() > 0)
				cur = rx_q.pop_front();
			else if (rbit == 0)
				cur = IDLE_CHAR;
			rx_data_line <= cur[rbit];
			rbit = (rbit + 1) % 8;
		end
	end
endmodule

// [test_sync_dataset_serial_link.sv]
// Self-checking bench for the synchronous data set link
`timescale 1ns/1ps
module test_sync_dataset_serial_link
	import sdl_pkg::*;
;
	logic ref_clk = 0;
	logic rst_b = 0;
	logic ilk_en = 0;
	logic car_en = 0;
	logic cts_block = 0;
	logic tx_valid = 0;
	logic [7:0] tx_data = 8'h00;
	wire rx_bit_clock, tx_bit_clock, clear_to_send, carrier_detect, interlock_ok;
	wire rx_data_line, tx_data_line, send_request, tx_ready, rx_valid;
	wire link_ready, carrier_on, rx_synced;
	wire [7:0] rx_data;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	int n;
	// Rows: byte sent each way, expected back unchanged
	logic [7:0] rows [5] = '{8'h00, 8'hff, 8'h01, 8'h80, 8'ha5};

	always #4 ref_clk = ~ref_clk;

	sdl_link u_sdl_link (.ref_clk(ref_clk), .rst_b(rst_b), .rx_bit_clock(rx_bit_clock),
		.tx_bit_clock(tx_bit_clock), .clear_to_send(clear_to_send),
		.carrier_detect(carrier_detect), .interlock_ok(interlock_ok),
		.rx_data_line(rx_data_line), .tx_data_line(tx_data_line),
		.send_request(send_request), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
		.link_ready(link_ready), .carrier_on(carrier_on), .rx_synced(rx_synced));

	sdl_dataset_model u_sdl_dataset_model (.send_request(send_request),
		.tx_data_line(tx_data_line), .ilk_en(ilk_en), .car_en(car_en),
		.cts_block(cts_block), .tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock),
		.clear_to_send(clear_to_send), .carrier_detect(carrier_detect),
		.interlock_ok(interlock_ok), .rx_data_line(rx_data_line));

	// Compare and count
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Offer a byte at a falling edge, hold until taken
	task automatic push(logic [7:0] b);
		tx_valid = 1;
		tx_data = b;
		n = 0;
		while (tx_ready !== 1 && n < 4000) begin
			@(negedge ref_clk);
			n++;
		end
		@(negedge ref_clk);
	endtask

	// Bounded waits
	task automatic wait_got(int k);
		n = 0;
		while (u_sdl_dataset_model.got_q.size() < k && n < 4000) begin
			@(negedge ref_clk);
			n++;
		end
	endtask
	task automatic wait_rx();
		n = 0;
		while (rx_valid !== 1 && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
	endtask
	task automatic wait_sr(logic lvl);
		n = 0;
		while (send_request !== lvl && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			results();
		end
	end

	initial begin
		repeat (8) @(negedge ref_clk);
		chk("tx_data_line", LINE_MARK, tx_data_line);
		chk("send_request", LINE_MARK, send_request);
		rst_b = 1;
		n = 0;
		while (u_sdl_dataset_model.idle_cnt < 2 && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
		// Nothing to send: idle fill, request off; off lines read as mark
		chk("idle fill", 1, u_sdl_dataset_model.idle_cnt >= 2);
		chk("send_request", LINE_MARK, send_request);
		chk("link_ready", 0, link_ready);
		chk("carrier_on", 0, carrier_on);
		ilk_en = 1;
		car_en = 1;
		n = 0;
		while (rx_synced !== 1 && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
		chk("link_ready", 1, link_ready);
		chk("carrier_on", 1, carrier_on);
		chk("rx_synced", 1, rx_synced);
		// Row loop: each byte out over the link and back in
		foreach (rows[i]) begin
			push(rows[i]);
			tx_valid = 0;
			wait_got(i + 1);
			chk("tx byte", rows[i], u_sdl_dataset_model.got_q[i]);
			u_sdl_dataset_model.rx_q.push_back(rows[i]);
			wait_rx();
			chk("rx_valid", 1, rx_valid);
			chk("rx_data", rows[i], rx_data);
			@(negedge ref_clk);
		end
		wait_sr(LINE_MARK);
		chk("send_request", LINE_MARK, send_request);
		// Clear withheld: back-to-back fill to depth, then refused
		cts_block = 1;
		for (int i = 0; i < FIFO_DEPTH; i++)
			push(8'h10 + i[7:0]);
		tx_valid = 0;
		wait_sr(LINE_SPACE);
		chk("tx_ready", 0, tx_ready);
		chk("send_request", LINE_SPACE, send_request);
		chk("held", 5, u_sdl_dataset_model.got_q.size());
		// Interlock lost while waiting drops the request
		ilk_en = 0;
		wait_sr(LINE_MARK);
		chk("send_request", LINE_MARK, send_request);
		ilk_en = 1;
		cts_block = 0;
		wait_got(5 + FIFO_DEPTH);
		for (int i = 0; i < FIFO_DEPTH; i++)
			chk("fill byte", 8'h10 + i[7:0], u_sdl_dataset_model.got_q[5 + i]);
		wait_sr(LINE_MARK);
		chk("send_request", LINE_MARK, send_request);
		chk("tx_ready", 1, tx_ready);
		// Carrier lost: receiver drops lock
		car_en = 0;
		repeat (16) @(negedge ref_clk);
		chk("rx_synced", 0, rx_synced);
		// Reset in mid-run: lines back to mark, received byte cleared
		rst_b = 0;
		repeat (2) @(negedge ref_clk);
		chk("tx_data_line", LINE_MARK, tx_data_line);
		chk("send_request", LINE_MARK, send_request);
		chk("link_ready", 0, link_ready);
		chk("rx_data", 8'h00, rx_data);
		results();
	end
endmodule
